// ===== dao_pkg.sv
// shared constants and types for the dsp adder/output stage
package dao_pkg;
    typedef enum logic [2:0] {MD_SIMPLE, MD_MAC, MD_ADD2, MD_ADD4, MD_M36} dao_mode_e;
    localparam int OPW = 18;
    localparam int ACW = 52;
    localparam int NSB = 4;
    localparam int AXW = 4;
    localparam logic [3:0] CFG_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam int CFG_MODE = 0;
    localparam int CFG_W9 = 3;
    localparam int CFG_PIPE = 4;
    localparam int CFG_OREG = 5;
    localparam int CFG_ASL = 6;
    localparam int CFG_SLL = 8;
    localparam int CFG_SGL = 10;
    localparam int CFG_SET = 12;
    localparam logic [31:0] CFG_MASK = 32'h000f_ffff;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam int STAT_OVF = 0;
    localparam int STAT_BAD = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== dao_adder_output_stage.sv
// dsp adder/output stage with product pipeline, adders, accumulators and axi4-lite config
`timescale 1ns/1ns
`default_nettype none
module dao_adder_output_stage
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dao_pkg::AXW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [dao_pkg::AXW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [dao_pkg::NSB-1:0][dao_pkg::OPW-1:0] opa,
    input wire logic [dao_pkg::NSB-1:0][dao_pkg::OPW-1:0] opb,
    input wire logic sign_a,
    input wire logic sign_b,
    input wire logic [1:0] addnsub,
    input wire logic [1:0] accum_sload,
    input wire logic [3:0] set_ena,
    input wire logic [3:0] set_clr,
    output logic [dao_pkg::NSB-1:0][dao_pkg::ACW-1:0] res,
    output logic [1:0] overflow
);
    import dao_pkg::*;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    function automatic logic [37:0] mul18(input logic [17:0] x, input logic [17:0] y,
        input logic sx, input logic sy);
        logic signed [18:0] xs;
        logic signed [18:0] ys;
        logic signed [37:0] p;
        xs = $signed({sx & x[17], x});
        ys = $signed({sy & y[17], y});
        p = xs * ys;
        return p;
    endfunction

    function automatic logic [18:0] mul9(input logic [8:0] x, input logic [8:0] y,
        input logic sx, input logic sy);
        logic signed [9:0] xs;
        logic signed [9:0] ys;
        logic signed [18:0] p;
        xs = $signed({sx & x[8], x});
        ys = $signed({sy & y[8], y});
        p = xs * ys;
        return p;
    endfunction

    // sign-extends a full 18x18 product or one 9x9 half to accumulator width
    function automatic logic [51:0] ext(input logic [37:0] p, input logic w9, input logic hi);
        logic [18:0] h;
        h = hi ? p[37:19] : p[18:0];
        return w9 ? {{33{h[18]}}, h} : {{14{p[37]}}, p};
    endfunction

    function automatic logic [51:0] addsub(input logic [51:0] a, input logic [51:0] b,
        input logic add);
        return add ? a + b : a - b;
    endfunction

    // one extra bit catches signed overflow or unsigned carry/borrow
    function automatic logic [52:0] accum(input logic [51:0] a, input logic [51:0] b,
        input logic add, input logic sgn);
        logic [52:0] ae;
        logic [52:0] be;
        logic [52:0] s;
        ae = {sgn & a[51], a};
        be = {sgn & b[51], b};
        s = add ? ae + be : ae - be;
        return {sgn ? (s[52] ^ s[51]) : s[52], s[51:0]};
    endfunction

    function automatic logic [1:0] dly(input logic [1:0] l, input logic [1:0] v0,
        input logic [1:0] v1, input logic [1:0] v2);
        if (l == 2'h0)
            return v0;
        else if (l == 2'h1)
            return v1;
        return v2;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] word(input logic [3:0] a);
        return {a[3:2], 2'h0};
    endfunction

    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [3:0] waddr_r, waddr_nxt, wstrb_r, wstrb_nxt;
    logic [31:0] wdata_r, wdata_nxt, cfg_r, cfg_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [5:0] ctl_c, d1_r, d1_nxt, d2_r, d2_nxt;
    logic [3:0][37:0] pc, pp_r, pp_nxt, pp;
    logic [3:0][51:0] ad, lane_c, res_r, res_nxt;
    logic [1:0][51:0] sm, mp;
    logic [1:0][52:0] ac;
    logic [1:0] ovf_r, ovf_nxt, as_d, sl_d, sg_d;
    logic [3:0] len, lcl;
    logic [73:0] m36;
    logic [2:0] mraw;
    dao_mode_e mode;
    logic cfg_bad, w9, pipe_en, oreg_en;
    logic [1:0] as_lat, sl_lat, sg_lat;

    // an unknown mode code falls back to simple mode, so only one mode is ever live
    assign mraw = cfg_r[CFG_MODE +: 3];
    assign cfg_bad = mraw > 3'(MD_M36);
    assign mode = cfg_bad ? MD_SIMPLE : dao_mode_e'(mraw);
    assign w9 = cfg_r[CFG_W9];
    assign pipe_en = cfg_r[CFG_PIPE];
    assign oreg_en = cfg_r[CFG_OREG];
    assign as_lat = cfg_r[CFG_ASL +: 2];
    assign sl_lat = cfg_r[CFG_SLL +: 2];
    assign sg_lat = cfg_r[CFG_SGL +: 2];

    always_comb
    begin
        aw_have_nxt = aw_have_r;
        waddr_nxt = waddr_r;
        w_have_nxt = w_have_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        cfg_nxt = cfg_r;
        if (awvalid && awready_r)
        begin
            aw_have_nxt = 1'b1;
            waddr_nxt = awaddr;
        end
        if (wvalid && wready_r)
        begin
            w_have_nxt = 1'b1;
            wdata_nxt = wdata;
            wstrb_nxt = wstrb;
        end
        if (bvalid_r && bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (aw_have_r && w_have_r && !bvalid_r)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            if (word(waddr_r) == CFG_OFS)
                cfg_nxt = wmerge(cfg_r, wdata_r, wstrb_r) & CFG_MASK;
            else if (word(waddr_r) != STAT_OFS)
                bresp_nxt = RESP_SLVERR;
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            cfg_r <= CFG_RST;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = '0;
            if (word(araddr) == CFG_OFS)
                rdata_nxt = cfg_r;
            else if (word(araddr) == STAT_OFS)
            begin
                rdata_nxt[STAT_OVF +: 2] = ovf_r;
                rdata_nxt[STAT_BAD] = cfg_bad;
            end
            else
                rresp_nxt = RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // control delay line: taps 0, 1 or 2 match the depth of the data path
    assign ctl_c = {accum_sload, addnsub, sign_b, sign_a};
    assign sg_d = dly(sg_lat, ctl_c[1:0], d1_r[1:0], d2_r[1:0]);
    assign as_d = dly(as_lat, ctl_c[3:2], d1_r[3:2], d2_r[3:2]);
    assign sl_d = dly(sl_lat, ctl_c[5:4], d1_r[5:4], d2_r[5:4]);

    // products exist only inside the block; there is no external adder input
    always_comb
    begin
        d1_nxt = ctl_c;
        d2_nxt = d1_r;
        for (int i = 0; i < NSB; i++)
        begin
            if (mode == MD_M36)
                pc[i] = mul18(opa[i % 2], opb[i / 2], sign_a & (i % 2 == 1),
                    sign_b & (i / 2 == 1));
            else if (w9)
                pc[i] = {mul9(opa[i][17:9], opb[i][17:9], sign_a, sign_b),
                    mul9(opa[i][8:0], opb[i][8:0], sign_a, sign_b)};
            else
                pc[i] = mul18(opa[i], opb[i], sign_a, sign_b);
        end
        pp_nxt = pc;
    end

    assign pp = pipe_en ? pp_r : pc;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            d1_r <= '0;
            d2_r <= '0;
            pp_r <= '0;
        end
        else
        begin
            d1_r <= d1_nxt;
            d2_r <= d2_nxt;
            pp_r <= pp_nxt;
        end
    end

    always_comb
    begin
        for (int j = 0; j < NSB; j++)
        begin
            len[j] = set_ena[cfg_r[CFG_SET + 2*j +: 2]];
            lcl[j] = set_clr[cfg_r[CFG_SET + 2*j +: 2]];
        end
    end

    always_comb
    begin
        lane_c = '0;
        m36 = (74'($signed(pp[3])) <<< 36) + (74'($signed(pp[1])) <<< 18)
            + (74'($signed(pp[2])) <<< 18) + 74'($signed(pp[0]));
        for (int k = 0; k < NSB; k++)
        begin
            if (w9)
                ad[k] = addsub(ext(pp[k], 1'b1, 1'b0), ext(pp[k], 1'b1, 1'b1),
                    as_d[k / 2]);
            else if (k < 2)
                ad[k] = addsub(ext(pp[2*k], 1'b0, 1'b0), ext(pp[2*k+1], 1'b0, 1'b0),
                    as_d[k]);
            else
                ad[k] = '0;
        end
        sm[0] = ad[0] + ad[1];
        sm[1] = ad[2] + ad[3];
        for (int k = 0; k < 2; k++)
        begin
            mp[k] = ext(pp[2*k+1], w9, 1'b0);
            ac[k] = accum(res_r[2*k+1], mp[k], as_d[k], sg_d[0] | sg_d[1]);
        end
        case (mode)
            MD_MAC:
            begin
                for (int k = 0; k < 2; k++)
                begin
                    lane_c[2*k+1] = sl_d[k] ? mp[k] : ac[k][51:0];
                end
            end
            MD_ADD2:
                lane_c = ad;
            MD_ADD4:
            begin
                lane_c[0] = sm[0];
                lane_c[1] = sm[1];
            end
            MD_M36:
            begin
                lane_c[0] = {16'h0, m36[35:0]};
                lane_c[1] = {{16{m36[71]}}, m36[71:36]};
            end
            default:
            begin
                for (int j = 0; j < NSB; j++)
                begin
                    lane_c[j] = w9 ? {14'h0, pp[j]} : ext(pp[j], 1'b0, 1'b0);
                end
            end
        endcase
    end

    // with output registers off a lane outside accumulate mode still passes one flop but ignores its set
    always_comb
    begin
        res_nxt = res_r;
        for (int j = 0; j < NSB; j++)
        begin
            if (!oreg_en && mode != MD_MAC)
                res_nxt[j] = lane_c[j];
            else if (lcl[j])
                res_nxt[j] = '0;
            else if (len[j])
                res_nxt[j] = lane_c[j];
        end
        for (int k = 0; k < 2; k++)
        begin
            if (mode != MD_MAC || lcl[2*k+1])
                ovf_nxt[k] = 1'b0;
            else if (len[2*k+1])
                ovf_nxt[k] = !sl_d[k] & ac[k][52];
            else
                ovf_nxt[k] = ovf_r[k];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            res_r <= '0;
            ovf_r <= '0;
        end
        else
        begin
            res_r <= res_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign res = res_r;
    assign overflow = ovf_r;

    // helper values seen only by the checks
    logic [51:0] chk_p0, chk_p1;
    logic [71:0] chk_m;
    assign chk_p0 = ext(pp[0], 1'b0, 1'b0);
    assign chk_p1 = ext(pp[1], 1'b0, 1'b0);
    assign chk_m = {36'h0, opa[1], opa[0]} * {36'h0, opb[1], opb[0]};

    sequence wr_take_s;
        awvalid && awready_r && wvalid && wready_r;
    endsequence
    sequence wr_done_s;
        ##2 bvalid_r ##1 (bvalid_r || $past(bready));
    endsequence

    axi_wr_resp_a: assert property (wr_take_s |-> wr_done_s)
        else $error("write response not raised two cycles after address and data");
    pipe_reg_a: assert property (pipe_en && $past(aresetn) |-> pp == $past(pc))
        else $error("pipelined products do not lag the multiplier by one cycle");
    acc_oreg_a: assert property (mode == MD_MAC && !len[1] && !lcl[1]
        |=> $stable(res_r[1]))
        else $error("accumulator lane changed without its enable");
    add_sub_a: assert property (mode == MD_ADD2 && !w9 && !oreg_en && !pipe_en
        && as_lat == 2'h0 |=> res_r[0] == ($past(addnsub[0]) ? $past(chk_p0) + $past(chk_p1)
        : $past(chk_p0) - $past(chk_p1)))
        else $error("first-level adder direction wrong");
    ans_lat_a: assert property (as_lat == 2'h2 && $past(aresetn, 2)
        |-> as_d == $past(addnsub, 2))
        else $error("add/sub select not delayed by two");
    sload_a: assert property (mode == MD_MAC && sl_d[0] && len[1] && !lcl[1]
        |=> res_r[1] == $past(mp[0]))
        else $error("accumulator load did not take the product");
    ovf_live_a: assert property (mode == MD_MAC && len[1] && !lcl[1] && !sl_d[0]
        |=> ovf_r[0] == $past(ac[0][52]))
        else $error("overflow flag does not follow the last step");
    sum_four_a: assert property (mode == MD_ADD4 && !oreg_en
        |=> res_r[0] == $past(ad[0]) + $past(ad[1]))
        else $error("four-product sum wrong");
    ovf_mode_a: assert property (mode != MD_MAC |=> ovf_r == 2'h0)
        else $error("overflow flag set outside accumulation");
    simple_pass_a: assert property (mode == MD_SIMPLE && !w9 && !oreg_en && !pipe_en
        |=> res_r[0] == $past(chk_p0))
        else $error("simple mode product not passed out");
    m36_low_a: assert property (mode == MD_M36 && !oreg_en && !pipe_en
        |=> res_r[0][35:0] == $past(chk_m[35:0]))
        else $error("36x36 low half wrong");
endmodule // dao_adder_output_stage
`default_nettype wire

// ===== dao_fabric_model.sv
// fabric-side model that registers operands and controls into the adder/output stage
`timescale 1ns/1ns
`default_nettype none
module dao_fabric_model
(
    input wire logic aclk,
    input wire logic [dao_pkg::NSB-1:0][dao_pkg::OPW-1:0] n_opa,
    input wire logic [dao_pkg::NSB-1:0][dao_pkg::OPW-1:0] n_opb,
    input wire logic [13:0] n_ctl,
    output logic [dao_pkg::NSB-1:0][dao_pkg::OPW-1:0] opa,
    output logic [dao_pkg::NSB-1:0][dao_pkg::OPW-1:0] opb,
    output logic sign_a,
    output logic sign_b,
    output logic [1:0] addnsub,
    output logic [1:0] accum_sload,
    output logic [3:0] set_ena,
    output logic [3:0] set_clr
);
    import dao_pkg::*;
    initial
    begin
        {opa, opb, sign_a, sign_b, addnsub, accum_sload, set_ena, set_clr} = '0;
    end
    // one sign pair feeds multipliers and accumulators; the stage delays it to the accumulators by the sg_lat tap of 0, 1 or 2 cycles
    always @(posedge aclk)
    begin
        opa <= n_opa;
        opb <= n_opb;
        {sign_a, sign_b, addnsub, accum_sload, set_ena, set_clr} <= n_ctl;
    end
endmodule // dao_fabric_model
`default_nettype wire

// ===== dao_adder_output_stage_tb.sv
// self-checking testbench for the dsp adder/output stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dao_adder_output_stage_tb;
    import dao_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [AXW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, sign_a, sign_b;
    logic [1:0] bresp, rresp, addnsub, accum_sload, overflow;
    logic [31:0] rdata;
    logic [3:0] set_ena, set_clr;
    logic [NSB-1:0][OPW-1:0] opa, opb, n_a = '0, n_b = '0;
    logic [NSB-1:0][OPW-1:0] ha [4], hb [4];
    logic [1:0] hs [4];
    logic [13:0] n_c = '0;
    logic [NSB-1:0][ACW-1:0] res;
    logic [31:0] cfg = '0;
    logic sa = 1'h0, sb = 1'h0, mon = 1'h0, ov = 1'h0;
    logic [51:0] acc = '0;
    int seed = 30535;
    int cyc = 0, pipe = 0, lat = 0, wd = 0, err_total = 0, n_tests = 0;

    dao_fabric_model dao_fabric_model_inst
    (
        .aclk, .n_opa(n_a), .n_opb(n_b), .n_ctl(n_c), .opa, .opb, .sign_a, .sign_b,
        .addnsub, .accum_sload, .set_ena, .set_clr
    );
    dao_adder_output_stage dao_adder_output_stage_inst
    (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .opa, .opb, .sign_a, .sign_b, .addnsub, .accum_sload, .set_ena,
        .set_clr, .res, .overflow
    );

    initial
    begin
        forever #50 aclk = ~aclk;
    end

    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        wd++;
        if (wd == 3000)
        begin
            err_total++;
            finish_test();
        end
    end

    // handshakes are seen at the falling edge; outputs only move on rising edges
    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic at, wt, bt;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        bt = 1'h0;
        while (!bt)
        begin
            @(negedge aclk);
            at = awvalid & awready;
            wt = wvalid & wready;
            bt = bvalid & bready;
            if (bt) `CHK(bresp, er)
            @(posedge aclk);
            if (at) awvalid <= 1'h0;
            if (wt) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask

    task axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic at, rt;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        rt = 1'h0;
        while (!rt)
        begin
            @(negedge aclk);
            at = arvalid & arready;
            rt = rvalid & rready;
            if (rt) `CHK({rresp, rdata}, {er, ed})
            @(posedge aclk);
            if (at) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask

    function automatic logic signed [73:0] mx(input logic [35:0] a, input logic [35:0] b,
        input int w);
        logic signed [73:0] x, y;
        x = {38'h0, a};
        y = {38'h0, b};
        if (sa && a[w-1]) x = x - (74'sh1 <<< w);
        if (sb && b[w-1]) y = y - (74'sh1 <<< w);
        return x * y;
    endfunction

    // expected lane value from the history of applied inputs
    function automatic logic [51:0] ex(input int j);
        int d, s;
        logic signed [73:0] p [4];
        logic signed [73:0] r [4];
        logic signed [73:0] q0, q1;
        d = (cyc - 1 - pipe) & 3;
        s = (cyc - 1 - lat) & 3;
        // 9x9 pairs: the low product comes first, the high one is added or taken away
        for (int k = 0; k < 4; k++)
        begin
            p[k] = mx(ha[d][k], hb[d][k], 18);
            q0 = mx(ha[d][k][17:9], hb[d][k][17:9], 9);
            q1 = mx(ha[d][k][8:0], hb[d][k][8:0], 9);
            r[k] = hs[s][k / 2] ? q1 + q0 : q1 - q0;
        end
        if (!cfg[CFG_W9])
        begin
            r[0] = hs[s][0] ? p[0] + p[1] : p[0] - p[1];
            r[1] = hs[s][1] ? p[2] + p[3] : p[2] - p[3];
            r[2] = '0;
            r[3] = '0;
        end
        case (cfg[2:0])
            MD_ADD2: return r[j][51:0];
            MD_ADD4: return j ? 52'(r[2] + r[3]) : 52'(r[0] + r[1]);
            MD_M36:
            begin
                q0 = mx({ha[d][1], ha[d][0]}, {hb[d][1], hb[d][0]}, 36);
                return j ? 52'(q0 >>> 36) : {16'h0, q0[35:0]};
            end
            default:
            begin
                if (!cfg[CFG_W9]) return p[j][51:0];
                q0 = mx(ha[d][j][17:9], hb[d][j][17:9], 9);
                q1 = mx(ha[d][j][8:0], hb[d][j][8:0], 9);
                return {14'h0, q0[18:0], q1[18:0]};
            end
        endcase
    endfunction

    task step;
        cyc++;
        ha[cyc & 3] = n_a;
        hb[cyc & 3] = n_b;
        hs[cyc & 3] = n_c[11:10];
        @(negedge aclk);
    endtask

    task automatic rtest(input logic [31:0] c, input logic s_a, input logic s_b, input int nl);
        logic [95:0] rv;
        axi_wr(CFG_OFS, c, 4'hf, RESP_OKAY);
        cfg = c;
        pipe = int'(c[CFG_PIPE]);
        lat = int'(c[7:6]);
        sa = s_a;
        sb = s_b;
        @(negedge aclk);
        for (int i = 0; i < 24; i++)
        begin
            rv = {$random(seed), $random(seed), $random(seed)};
            n_a = (i == 3) ? '1 : (i == 4) ? {4{18'h20000}} : rv[71:0];
            n_c = {s_a, s_b, rv[83:72]};
            rv = {$random(seed), $random(seed), $random(seed)};
            n_b = (i == 3) ? '1 : rv[71:0];
            step();
            for (int j = 0; j < nl; j++)
                if (i > 2) `CHK(res[j], ex(j))
        end
        $display("random test cfg %h done", c);
    endtask

    task ms(input logic [17:0] a, input logic [17:0] b, input logic ad, input logic sl,
        input logic en, input logic cl);
        n_a[1] = a;
        n_b[1] = b;
        n_a[3] = a;
        n_b[3] = b;
        // both accumulators run the same steps so either overflow flag can be judged
        n_c = {2'h0, ad, ad, sl, sl, 1'h1, en, 2'h3, 1'h0, cl, 2'h0};
        step();
        if (mon)
        begin
            `CHK(res[1], acc)
            `CHK({res[3], overflow[1]}, {acc, ov})
            `CHK(overflow[0], ov)
            `CHK({res[0], res[2]}, 104'h0)
        end
        mon = 1'h1;
        if (cl) {ov, acc} = '0;
        else if (en && sl) {ov, acc} = {1'h0, 52'(a * b)};
        else if (en) {ov, acc} = ad ? {1'h0, acc} + 53'(a * b) : {1'h0, acc} - 53'(a * b);
    endtask

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        axi_rd(CFG_OFS, CFG_RST, RESP_OKAY);
        axi_wr(CFG_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_rd(CFG_OFS, CFG_MASK, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h0000_0004, RESP_OKAY);
        axi_wr(CFG_OFS, 32'h0, 4'h1, RESP_OKAY);
        axi_rd(CFG_OFS, 32'h000f_ff00, RESP_OKAY);
        axi_wr(STAT_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_wr(4'h8, 32'h1234_5678, 4'hf, RESP_SLVERR);
        axi_rd(4'h8, 32'h0, RESP_SLVERR);
        $display("register test done");
        rtest(32'h0, 1'h0, 1'h0, 4);
        rtest(32'h0, 1'h1, 1'h1, 4);
        rtest(32'h8, 1'h1, 1'h0, 4);
        rtest(32'h10, 1'h0, 1'h1, 4);
        rtest(32'h82, 1'h1, 1'h1, 2);
        rtest(32'h2, 1'h0, 1'h1, 2);
        rtest(32'h4a, 1'h1, 1'h0, 4);
        rtest(32'h3, 1'h1, 1'h1, 1);
        rtest(32'h1b, 1'h0, 1'h1, 2);
        rtest(32'h4, 1'h1, 1'h0, 2);
        // borrow then carry then a clean step: the flag must drop again
        axi_wr(CFG_OFS, 32'h0008_8021, 4'hf, RESP_OKAY);
        @(negedge aclk);
        ms(18'h3, 18'h5, 1'h1, 1'h1, 1'h1, 1'h0);
        ms(18'h2, 18'h2, 1'h1, 1'h0, 1'h1, 1'h0);
        ms(18'h4, 18'h5, 1'h0, 1'h0, 1'h1, 1'h0);
        ms(18'h1, 18'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        ms(18'h1, 18'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        ms(18'h7, 18'h7, 1'h1, 1'h0, 1'h0, 1'h0);
        ms(18'h7, 18'h7, 1'h1, 1'h0, 1'h1, 1'h1);
        ms(18'h1, 18'h1, 1'h0, 1'h1, 1'h1, 1'h0);
        ms(18'h0, 18'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        $display("accumulate test done");
        finish_test();
    end
endmodule // dao_adder_output_stage_tb
`default_nettype wire
